// ---- sdf_cfg.svh ----
// register offsets, reset values and timing counts
`ifndef SDF_CFG_SVH
`define SDF_CFG_SVH
`define SDF_REG_CTRL 8'h00
`define SDF_REG_STAT 8'h04
`define SDF_REG_ISR 8'h08
`define SDF_REG_IMR 8'h0c
`define SDF_REG_LOAD 8'h10
`define SDF_REG_CMD 8'h14
`define SDF_CTRL_RST 15'h07c0
`define SDF_LOAD_RST 26'h3ff0000
`define SDF_MRES_FULL 4'h8
`define SDF_CLK_NS 40
`define SDF_GLITCH_NS 60
`define SDF_GLITCH_CYC ((`SDF_GLITCH_NS + `SDF_CLK_NS - 1) / `SDF_CLK_NS)
`define SDF_DEAD_NS 80
`define SDF_DEAD_CYC ((`SDF_DEAD_NS + `SDF_CLK_NS - 1) / `SDF_CLK_NS)
`define SDF_WORD_BITS 20
`define SDF_QUARTER 10'h100
`define SDF_GATE_FWD 4'b1001
`define SDF_GATE_REV 4'b0110
`define SDF_GATE_SLOW 4'b0101
`endif

// ---- sdf_ctrl_model.sv ----
// controller model driving step, direction and serial lines
`timescale 1ns/1ns
`default_nettype none
module sdf_ctrl_model (
  input wire logic clk_i,
  input wire logic serial_data_out_i,
  output logic step_o,
  output logic dir_o,
  output logic chip_select_n_o,
  output logic serial_clk_o,
  output logic serial_data_in_o
);
  logic [19:0] status_seen;
  initial begin
    step_o = 1'b0;
    dir_o = 1'b0;
    chip_select_n_o = 1'b1;
    serial_clk_o = 1'b0;
    serial_data_in_o = 1'b0;
    status_seen = 20'h0;
  end
  // status bits arrive while selected
  always @(posedge serial_clk_o) begin
    if (!chip_select_n_o)
      status_seen <= {status_seen[18:0], serial_data_out_i};
  end
  task automatic toggle(input int hold);
    step_o <= ~step_o;
    repeat (hold) @(posedge clk_i);
  endtask
  // dir glitch, settled dir, then a step pulse of given width
  task automatic pulse(input logic d, input int hold);
    dir_o <= ~d;
    @(posedge clk_i);
    dir_o <= d;
    repeat (4) @(posedge clk_i);
    toggle(hold);
    toggle(4);
  endtask
  // n bits msb first, sck slow enough for sampling
  task automatic word(input logic [19:0] w, input int n, input logic sel_n);
    chip_select_n_o <= sel_n;
    repeat (4) @(posedge clk_i);
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_in_o <= w[i];
      repeat (4) @(posedge clk_i);
      serial_clk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      serial_clk_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    chip_select_n_o <= 1'b1;
    serial_data_in_o <= ~serial_data_in_o;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic lines(input logic c, input logic d);
    serial_clk_o <= c;
    serial_data_in_o <= d;
  endtask
endmodule
`default_nettype wire

// ---- sdf_frontend.sv ----
// step/direction microstep front end with serial, chopper and apb registers
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "sdf_cfg.svh"
module sdf_frontend import sdf_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic step_i,
  input wire logic dir_i,
  input wire logic chip_select_n_i,
  input wire logic serial_clk_i,
  input wire logic serial_data_in_i,
  output logic serial_data_out_o,
  output logic serial_data_out_en_o,
  input wire logic bridge_enable_n_i,
  input wire logic clk_pin_i,
  input wire logic test_mode_in_i,
  input wire logic [1:0] cmp_i,
  input wire logic [9:0] load_i,
  output logic [3:0] gate_a_o,
  output logic [3:0] gate_b_o,
  output logic [7:0] target_a_o,
  output logic [7:0] target_b_o,
  output logic osc_en_o,
  output logic stall_flag_out_o,
  output logic test_mode_o,
  output logic scan_in_o,
  output logic scan_en_o,
  output logic irq_o
);
  logic [9:0] sy1, sy2;
  logic sck_d, cs_d, stall_d, cmd_done;
  logic flt_q [2];
  logic [1:0] flt_cnt [2];
  logic step_prev;
  logic [9:0] pos;
  logic [14:0] ctrl;
  logic [25:0] loadcfg;
  logic [2:0] isr, imr;
  logic [19:0] rx, tx, cmd;
  logic [4:0] bit_cnt;
  logic [1:0][7:0] tgt_mag;
  logic [1:0] tgt_pol;
  logic [3:0] gate_q [2];

  // two-flop synchronisers for all pins except load_i, rst_i and the apb port
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sy1 <= 10'h024;
      sy2 <= 10'h024;
    end else begin
      sy1 <= {cmp_i, test_mode_in_i, clk_pin_i, bridge_enable_n_i, serial_data_in_i,
              serial_clk_i, chip_select_n_i, dir_i, step_i};
      sy2 <= sy1;
    end
  end
  wire [1:0] flt_in = sy2[1:0];
  wire cs_n_s = sy2[2];
  wire sck_s = sy2[3];
  wire sdi_s = sy2[4];
  wire en_n_s = sy2[5];
  wire clk_pin_s = sy2[6];
  wire test_s = sy2[7];
  wire [1:0] cmp_s = sy2[9:8];

  // glitch filters: a new level must persist for the filter time
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_flt
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          flt_q[g] <= 1'b0;
          flt_cnt[g] <= 2'h0;
        end else if (flt_in[g] == flt_q[g]) begin
          flt_cnt[g] <= 2'h0;
        end else if (flt_cnt[g] == 2'(`SDF_GLITCH_CYC - 1)) begin
          flt_q[g] <= flt_in[g];
          flt_cnt[g] <= 2'h0;
        end else begin
          flt_cnt[g] <= flt_cnt[g] + 2'h1;
        end
      end
    end
  endgenerate
  wire step_f = flt_q[0];
  wire dir_f = flt_q[1];

  // step edges and microstep counter
  wire double_edge_step = ctrl[0];
  wire spi_src = ctrl[1];
  wire [3:0] mres = ctrl[5:2];
  wire [4:0] cur_scale = ctrl[10:6];
  wire [3:0] toff = ctrl[14:11];
  wire step_evt = (step_f & ~step_prev) | (double_edge_step & ~step_f & step_prev);
  wire [3:0] mres_c = (mres > `SDF_MRES_FULL) ? `SDF_MRES_FULL : mres;
  wire [9:0] step_inc = 10'h001 << mres_c;
  wire [9:0] next_pos = dir_f ? pos - step_inc : pos + step_inc;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      step_prev <= 1'b0;
      pos <= 10'h000;
    end else begin
      step_prev <= step_f;
      if (step_evt) pos <= next_pos;
    end
  end

  // half-wave sine from a parabola over 512 phase steps
  function automatic logic [7:0] sdf_sine(input logic [8:0] ph);
    logic [17:0] prod;
    prod = {9'h000, ph} * (18'h00200 - {9'h000, ph});
    return (prod[17:8] > 10'h0ff) ? 8'hff : prod[15:8];
  endfunction

  function automatic logic [7:0] sdf_scale(input logic [7:0] m, input logic [4:0] cs,
                                           input logic light);
    logic [13:0] p;
    p = {6'h00, m} * {8'h00, ({1'b0, cs} + 6'h01)};
    return light ? {1'b0, p[12:6]} : p[12:5];
  endfunction

  wire [9:0] pos_b = pos + `SDF_QUARTER;
  wire [7:0] tab_a = sdf_sine(pos[8:0]);
  wire [7:0] tab_b = sdf_sine(pos_b[8:0]);
  wire cmd_cur = cmd[19:18] == 2'b00;
  wire [7:0] sel_a = spi_src ? cmd[16:9] : tab_a;
  wire [7:0] sel_b = spi_src ? cmd[7:0] : tab_b;
  wire sel_pa = spi_src ? cmd[17] : pos[9];
  wire sel_pb = spi_src ? cmd[8] : pos_b[9];
  wire light = load_i > loadcfg[25:16];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tgt_mag <= '0;
      tgt_pol <= 2'b00;
    end else begin
      tgt_mag[0] <= sdf_scale(sel_a, cur_scale, light);
      tgt_mag[1] <= sdf_scale(sel_b, cur_scale, light);
      tgt_pol <= {sel_pb, sel_pa};
    end
  end
  assign target_a_o = tgt_mag[0];
  assign target_b_o = tgt_mag[1];

  // chopper per coil: drive, dead, slow decay, dead
  generate
    for (g = 0; g < 2; g++) begin : g_chop
      sdf_chop_t st;
      logic [7:0] cnt;
      logic pol;
      logic [3:0] gdec;
      assign gdec = (st == SDF_ON) ? (pol ? `SDF_GATE_REV : `SDF_GATE_FWD) :
                    (st == SDF_OFF) ? `SDF_GATE_SLOW : 4'h0;
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          st <= SDF_OFF;
          cnt <= 8'h00;
          pol <= 1'b0;
          gate_q[g] <= 4'h0;
        end else begin
          gate_q[g] <= en_n_s ? 4'h0 : gdec;
          unique case (st)
            SDF_ON: if (en_n_s || cmp_s[g] || tgt_pol[g] != pol) begin
              st <= SDF_BBM_OFF;
              cnt <= 8'(`SDF_DEAD_CYC);
            end
            SDF_BBM_OFF: if (cnt == 8'h00) begin
              st <= SDF_OFF;
              cnt <= {toff, 4'h0};
            end else cnt <= cnt - 8'h01;
            SDF_OFF: if (cnt != 8'h00) cnt <= cnt - 8'h01;
              else if (!en_n_s && tgt_mag[g] != 8'h00) begin
                st <= SDF_BBM_ON;
                cnt <= 8'(`SDF_DEAD_CYC);
              end
            SDF_BBM_ON: if (cnt == 8'h00) begin
              st <= SDF_ON;
              pol <= tgt_pol[g];
            end else cnt <= cnt - 8'h01;
            default: st <= SDF_OFF;
          endcase
        end
      end
      property p_chop_end;
        @(posedge clk_i) disable iff (rst_i) st == SDF_ON && cmp_s[g] |=> st == SDF_BBM_OFF;
      endproperty
      a_chop_end: assert property (p_chop_end) else $error("drive phase not ended");
      property p_bbm;
        @(posedge clk_i) disable iff (rst_i)
          gate_q[g] != 4'h0 && $past(gate_q[g]) != 4'h0 |-> gate_q[g] == $past(gate_q[g]);
      endproperty
      a_bbm: assert property (p_bbm) else $error("switch overlap");
    end
  endgenerate
  assign gate_a_o = gate_q[0];
  assign gate_b_o = gate_q[1];

  // serial port: 20-bit command in, status out
  wire sck_rise = sck_s & ~sck_d;
  wire sck_fall = ~sck_s & sck_d;
  wire ser_act = ~cs_n_s & ~test_s;
  wire [19:0] status_w = {pos, stall_flag_out_o, osc_en_o, test_s, 7'h00};

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {sck_d, cs_d, cmd_done, serial_data_out_o, serial_data_out_en_o} <= 5'h08;
      rx <= 20'h00000;
      tx <= 20'h00000;
      cmd <= 20'h00000;
      bit_cnt <= 5'h00;
    end else begin
      sck_d <= sck_s;
      cs_d <= cs_n_s;
      serial_data_out_en_o <= ser_act;
      cmd_done <= 1'b0;
      if (!ser_act) begin
        bit_cnt <= 5'h00;
        if (!cs_d && bit_cnt == 5'(`SDF_WORD_BITS) && !test_s) begin
          cmd <= rx;
          cmd_done <= 1'b1;
        end
      end else if (cs_d) begin
        tx <= status_w;
        serial_data_out_o <= status_w[19];
      end else if (sck_rise) begin
        rx <= {rx[18:0], sdi_s};
        if (bit_cnt != 5'h1f) bit_cnt <= bit_cnt + 5'h01;
      end else if (sck_fall) begin
        tx <= {tx[18:0], 1'b0};
        serial_data_out_o <= tx[18];
      end
    end
  end

  // clock source, stall, test pins
  wire stall_now = load_i <= loadcfg[9:0];
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {osc_en_o, stall_flag_out_o, stall_d, test_mode_o, scan_in_o, scan_en_o} <= 6'h20;
    end else begin
      if (clk_pin_s) osc_en_o <= 1'b0;
      stall_flag_out_o <= stall_now;
      stall_d <= stall_flag_out_o;
      test_mode_o <= test_s;
      scan_in_o <= test_s & sdi_s;
      scan_en_o <= test_s & sck_s;
    end
  end

  // apb slave, zero wait states
  wire apb_setup = psel_i & ~penable_i;
  wire apb_wr = psel_i & penable_i & pready_o & pwrite_i;
  wire hit_ctrl = paddr_i == `SDF_REG_CTRL;
  wire hit_isr = paddr_i == `SDF_REG_ISR;
  wire hit_imr = paddr_i == `SDF_REG_IMR;
  wire hit_load = paddr_i == `SDF_REG_LOAD;
  wire mapped = hit_ctrl | hit_isr | hit_imr | hit_load |
                paddr_i == `SDF_REG_STAT | paddr_i == `SDF_REG_CMD;
  wire [31:0] rd_mux = hit_ctrl ? {17'h0, ctrl} : hit_isr ? {29'h0, isr} :
                       hit_imr ? {29'h0, imr} : hit_load ? {6'h0, loadcfg} :
                       paddr_i == `SDF_REG_STAT ? {12'h0, status_w} :
                       paddr_i == `SDF_REG_CMD ? {12'h0, cmd} : 32'h0;
  wire [2:0] events = {cmd_done, stall_flag_out_o & ~stall_d, step_evt};
  wire [2:0] w1c = (apb_wr && hit_isr) ? pwdata_i[2:0] : 3'h0;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {pready_o, pslverr_o, irq_o} <= 3'h0;
      prdata_o <= 32'h0;
      ctrl <= `SDF_CTRL_RST;
      loadcfg <= `SDF_LOAD_RST;
      isr <= 3'h0;
      imr <= 3'h0;
    end else begin
      pready_o <= apb_setup;
      pslverr_o <= apb_setup & ~mapped;
      prdata_o <= apb_setup ? rd_mux : 32'h0;
      if (apb_wr && hit_ctrl) ctrl <= pwdata_i[14:0];
      if (apb_wr && hit_load) loadcfg <= pwdata_i[25:0];
      if (apb_wr && hit_imr) imr <= pwdata_i[2:0];
      isr <= (isr & ~w1c) | events;
      irq_o <= |(isr & imr);
    end
  end

  property p_fwd;
    @(posedge clk_i) disable iff (rst_i) step_evt && !dir_f |=> pos == $past(next_pos);
  endproperty
  a_fwd: assert property (p_fwd) else $error("forward step wrong");
  property p_bwd;
    @(posedge clk_i) disable iff (rst_i) step_evt && dir_f |=> pos == $past(next_pos);
  endproperty
  a_bwd: assert property (p_bwd) else $error("backward step wrong");
  property p_single_edge;
    @(posedge clk_i) disable iff (rst_i) !double_edge_step && $fell(step_f) |=> $stable(pos);
  endproperty
  a_single_edge: assert property (p_single_edge) else $error("falling edge counted");
  property p_glitch;
    @(posedge clk_i) disable iff (rst_i)
      $changed(step_f) |-> $past(flt_in[0], 1) == step_f && $past(flt_in[0], 2) == step_f;
  endproperty
  a_glitch: assert property (p_glitch) else $error("short step pulse passed");
  property p_bridge_off;
    @(posedge clk_i) disable iff (rst_i) en_n_s |=> gate_a_o == 4'h0 && gate_b_o == 4'h0;
  endproperty
  a_bridge_off: assert property (p_bridge_off) else $error("bridge on while disabled");
  property p_osc;
    @(posedge clk_i) disable iff (rst_i) clk_pin_s || !osc_en_o |=> !osc_en_o;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator restarted");
  property p_word;
    @(posedge clk_i) disable iff (rst_i) cmd_done |-> $past(bit_cnt) == 5'(`SDF_WORD_BITS);
  endproperty
  a_word: assert property (p_word) else $error("command not 20 bits");
  property p_cs_idle;
    @(posedge clk_i) disable iff (rst_i)
      cs_n_s ##1 cs_n_s ##1 cs_n_s |-> bit_cnt == 5'h00 && !cmd_done;
  endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("traffic taken while deselected");
  property p_stall;
    @(posedge clk_i) disable iff (rst_i) ##1 stall_flag_out_o == $past(stall_now);
  endproperty
  a_stall: assert property (p_stall) else $error("stall flag wrong");
  c_step: cover property (@(posedge clk_i) disable iff (rst_i) step_evt && dir_f);
  c_double_edge_step: cover property (@(posedge clk_i) disable iff (rst_i) double_edge_step && $fell(step_f));
  c_cmd: cover property (@(posedge clk_i) disable iff (rst_i) cmd_done && cmd_cur);
  c_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
endmodule
`default_nettype wire

// ---- sdf_pkg.sv ----
// types of the step/direction front end
package sdf_pkg;
  typedef enum logic [3:0] {
    SDF_ON = 4'b0001,
    SDF_BBM_OFF = 4'b0010,
    SDF_OFF = 4'b0100,
    SDF_BBM_ON = 4'b1000
  } sdf_chop_t;
endpackage

// ---- tb_step_dir_microstep_frontend.sv ----
// self-checking bench of the step/direction front end
`timescale 1ns/1ns
`default_nettype none
`include "sdf_cfg.svh"
module tb_step_dir_microstep_frontend;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] paddr_i = 8'h00;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [31:0] pwdata_i = 32'h0;
  logic bridge_enable_n_i = 1'b0, clk_pin_i = 1'b0, test_mode_in_i = 1'b0;
  logic [1:0] cmp_i = 2'h0;
  logic [9:0] load_i = 10'h200;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, serial_data_out_o, serial_data_out_en_o, osc_en_o;
  logic stall_flag_out_o, test_mode_o, scan_in_o, scan_en_o, irq_o;
  logic step_i, dir_i, chip_select_n_i, serial_clk_i, serial_data_in_i;
  logic [3:0] gate_a_o, gate_b_o, prev_a, prev_b;
  logic [7:0] target_a_o, target_b_o;
  logic [9:0] pos;
  logic d;
  logic [32:0] exp_q[$];
  int fails = 0;
  int checks_done = 0;
  int seed = 94;
  sdf_frontend i_dut (.clk_i, .rst_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .step_i, .dir_i, .chip_select_n_i, .serial_clk_i,
    .serial_data_in_i, .serial_data_out_o, .serial_data_out_en_o, .bridge_enable_n_i,
    .clk_pin_i, .test_mode_in_i, .cmp_i, .load_i, .gate_a_o, .gate_b_o, .target_a_o,
    .target_b_o, .osc_en_o, .stall_flag_out_o, .test_mode_o, .scan_in_o, .scan_en_o, .irq_o);
  sdf_ctrl_model i_model (.clk_i, .serial_data_out_i(serial_data_out_o), .step_o(step_i),
    .dir_o(dir_i), .chip_select_n_o(chip_select_n_i), .serial_clk_o(serial_clk_i),
    .serial_data_in_o(serial_data_in_i));
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) cmp_i <= 2'($random(seed));
  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    checks_done++;
    if (seen !== want) begin
      fails++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic summarize;
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    paddr_i <= a;
    pwrite_i <= wr;
    pwdata_i <= v;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20)
      fails++;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] want);
    exp_q.push_back(want);
    apb(1'b0, a, 32'h0);
  endtask
  // read results and switch overlap watch
  always @(posedge clk_i) begin
    if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i && exp_q.size() > 0)
      check({pslverr_o, prdata_o}, exp_q.pop_front());
    if (!rst_i && prev_a != 4'h0 && gate_a_o != 4'h0)
      check(gate_a_o, prev_a);
    if (!rst_i && prev_b != 4'h0 && gate_b_o != 4'h0)
      check(gate_b_o, prev_b);
    prev_a <= rst_i ? 4'h0 : gate_a_o;
    prev_b <= rst_i ? 4'h0 : gate_b_o;
  end
  initial begin
    wait_clk(20000);
    fails++;
    summarize();
  end
  initial begin
    wait_clk(16);
    rst_i <= 1'b0;
    wait_clk(2);
    rd(`SDF_REG_CTRL, 33'h7c0);
    rd(`SDF_REG_LOAD, 33'h3ff0000);
    rd(8'h18, 33'h100000000);
    rd(`SDF_REG_STAT, 33'h100);
    $display("test reset done");
    pos = 10'h0;
    for (int r = 0; r <= 8; r++) begin
      d = 1'($random(seed));
      apb(1'b1, `SDF_REG_CTRL, 32'h7c0 | (r << 2));
      i_model.pulse(d, 4);
      pos = d ? pos - (10'h1 << r) : pos + (10'h1 << r);
      rd(`SDF_REG_STAT, {13'h0, pos, 10'h100});
    end
    apb(1'b1, `SDF_REG_CTRL, 32'h7c0);
    i_model.pulse(1'b0, 1);
    rd(`SDF_REG_STAT, {13'h0, pos, 10'h100});
    apb(1'b1, `SDF_REG_CTRL, 32'h7c1);
    i_model.pulse(1'b0, 4);
    pos = pos + 10'h2;
    rd(`SDF_REG_STAT, {13'h0, pos, 10'h100});
    $display("test stepping done");
    check(irq_o, 1'b0);
    apb(1'b1, `SDF_REG_IMR, 32'h1);
    wait_clk(3);
    check(irq_o, 1'b1);
    apb(1'b1, `SDF_REG_ISR, 32'h1);
    wait_clk(3);
    check(irq_o, 1'b0);
    $display("test interrupt done");
    apb(1'b1, `SDF_REG_LOAD, 32'h3ff0100);
    load_i <= 10'($random(seed)) & 10'h0ff;
    wait_clk(5);
    check(stall_flag_out_o, 1'b1);
    rd(`SDF_REG_STAT, {13'h0, pos, 10'h300});
    load_i <= 10'h300;
    wait_clk(5);
    check(stall_flag_out_o, 1'b0);
    $display("test stall done");
    apb(1'b1, `SDF_REG_CTRL, 32'h7c2);
    i_model.word(20'h10040, 20, 1'b0);
    check({13'h0, i_model.status_seen}, {13'h0, pos, 10'h100});
    rd(`SDF_REG_CMD, 33'h10040);
    check({target_a_o, target_b_o}, 16'h8040);
    i_model.word(20'h00001, 20, 1'b1);
    i_model.word(20'h00002, 19, 1'b0);
    rd(`SDF_REG_CMD, 33'h10040);
    apb(1'b1, `SDF_REG_CTRL, 32'h3c2);
    wait_clk(4);
    check(target_a_o, 8'h40);
    apb(1'b1, `SDF_REG_LOAD, 32'h01000100);
    wait_clk(4);
    check(target_a_o, 8'h20);
    $display("test serial done");
    bridge_enable_n_i <= 1'b1;
    wait_clk(4);
    repeat (8) begin
      wait_clk(1);
      check({gate_a_o, gate_b_o}, 8'h00);
    end
    bridge_enable_n_i <= 1'b0;
    test_mode_in_i <= 1'b1;
    i_model.lines(1'b1, 1'b1);
    wait_clk(4);
    check({test_mode_o, scan_in_o, scan_en_o, serial_data_out_en_o}, 4'b1110);
    test_mode_in_i <= 1'b0;
    i_model.lines(1'b0, 1'b0);
    $display("test pins done");
    clk_pin_i <= 1'b1;
    wait_clk(4);
    clk_pin_i <= 1'b0;
    wait_clk(4);
    check(osc_en_o, 1'b0);
    rd(`SDF_REG_STAT, {13'h0, pos, 10'h000});
    $display("test clock done");
    summarize();
  end
endmodule
`default_nettype wire
